/* File: core/cri_clkout.sv */
`timescale 1ns/1ns
`default_nettype none
module cri_clkout (
    input wire logic i_clk, // System clock
    input wire logic i_rstn, // Power-on reset, sync, active low
    input wire logic i_ce, // Clock enable, freezes state when low
    input wire logic i_external_reset_low, // External reset pin, active low
    input wire cri_pkg::cri_mode_s i_mode, // Mode bits from control register
    input wire logic i_mode_wr, // Mode write strobe
    output logic o_buffered_clock_out, // Clock output pin
    output logic o_init_busy, // Initialization in progress
    output var cri_pkg::cri_mode_s o_mode // Current mode bits
);
    import cri_pkg::*;

    logic rst_meta_reg;
    logic rst_sync_reg;
    cri_state_e state_reg;
    logic [CNT_W-1:0] cnt_reg;
    cri_mode_s mode_reg;
    logic phase_reg;
    logic [CNT_W-1:0] init_len_reg;

    // One place for the reset default of the mode bits
    function automatic cri_mode_s mode_default();
        return '{half_rate_sel: DIV_RESET, enable_bit: EN_RESET};
    endfunction

    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            rst_meta_reg <= 1'b0;
            rst_sync_reg <= 1'b0;
        end else if (i_ce) begin
            rst_meta_reg <= i_external_reset_low;
            rst_sync_reg <= rst_meta_reg;
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            state_reg <= CRI_ST_INIT;
            cnt_reg <= '0;
        end else if (i_ce) begin
            if (!rst_sync_reg) begin
                state_reg <= CRI_ST_HOLD;
                cnt_reg <= '0;
            end else begin
                case (state_reg)
                    CRI_ST_HOLD: begin
                        state_reg <= CRI_ST_INIT;
                        cnt_reg <= '0;
                    end
                    CRI_ST_INIT: begin
                        if (cnt_reg == CNT_LAST) begin
                            state_reg <= CRI_ST_RUN;
                        end
                        cnt_reg <= cnt_reg + CNT_W'(1);
                    end
                    CRI_ST_RUN: begin
                        state_reg <= CRI_ST_RUN;
                    end
                    default: begin
                        state_reg <= CRI_ST_INIT;
                        cnt_reg <= '0;
                    end
                endcase
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            mode_reg <= mode_default();
        end else if (i_ce) begin
            if (state_reg != CRI_ST_RUN || !rst_sync_reg) begin
                mode_reg <= mode_default();
            end else if (i_mode_wr) begin
                mode_reg <= i_mode;
            end
        end
    end

    // Output registered at twice the phase rate is not possible
    // on one edge, so full rate is modelled as a per-cycle toggle of the
    // sampled clock image; half rate toggles every second cycle.
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            phase_reg <= 1'b0;
            o_buffered_clock_out <= 1'b0;
        end else if (i_ce) begin
            phase_reg <= ~phase_reg;
            if (!mode_reg.enable_bit) begin
                o_buffered_clock_out <= 1'b0;
            end else if (!mode_reg.half_rate_sel || phase_reg) begin
                o_buffered_clock_out <= ~o_buffered_clock_out;
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            o_init_busy <= 1'b1;
            o_mode <= mode_default();
        end else if (i_ce) begin
            o_init_busy <= (state_reg != CRI_ST_RUN);
            o_mode <= mode_reg;
        end
    end

    // Helper for the assertions only: cycles spent in INIT so far
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            init_len_reg <= '0;
        end else if (i_ce) begin
            if (state_reg == CRI_ST_INIT) begin
                init_len_reg <= init_len_reg + CNT_W'(1);
            end else begin
                init_len_reg <= '0;
            end
        end
    end

    // Init still running eight cycles after leaving HOLD
    sequence init_start_s;
        i_ce && state_reg == CRI_ST_HOLD && rst_sync_reg;
    endsequence

    sequence mode_write_s;
        i_ce && i_mode_wr && state_reg == CRI_ST_RUN && rst_sync_reg;
    endsequence
    property init_len_p;
        @(posedge i_clk) disable iff (!i_rstn)
        init_start_s ##1 (i_ce && rst_sync_reg)[*8] |->
            state_reg == CRI_ST_INIT;
    endproperty
    init_length_a: assert property (init_len_p)
        else $error("init ended early");

    clk_disable_a: assert property (
        @(posedge i_clk) disable iff (!i_rstn)
        (i_ce && !mode_reg.enable_bit) |=> !o_buffered_clock_out)
        else $error("clock output not disabled");

    full_rate_a: assert property (
        @(posedge i_clk) disable iff (!i_rstn)
        (i_ce && mode_reg.enable_bit && !mode_reg.half_rate_sel)
        |=> o_buffered_clock_out != $past(o_buffered_clock_out))
        else $error("full rate not toggling");

    half_rate_a: assert property (
        @(posedge i_clk) disable iff (!i_rstn)
        (i_ce && mode_reg.enable_bit && mode_reg.half_rate_sel && !phase_reg)
        |=> $stable(o_buffered_clock_out))
        else $error("half rate toggled too often");

    defaults_a: assert property (
        @(posedge i_clk) disable iff (!i_rstn)
        (i_ce && state_reg == CRI_ST_INIT) |=>
            mode_reg.enable_bit == EN_RESET && mode_reg.half_rate_sel == DIV_RESET)
        else $error("mode not at default during init");

    hold_a: assert property (
        @(posedge i_clk) disable iff (!i_rstn)
        (i_ce && !rst_sync_reg) |=> state_reg == CRI_ST_HOLD)
        else $error("reset hold not entered");

    busy_a: assert property (
        @(posedge i_clk) disable iff (!i_rstn)
        (i_ce && state_reg == CRI_ST_RUN) |=> !o_init_busy)
        else $error("busy flag wrong");

    run_end_a: assert property (
        @(posedge i_clk) disable iff (!i_rstn)
        (i_ce && rst_sync_reg && state_reg == CRI_ST_INIT && cnt_reg == CNT_LAST)
        |=> state_reg == CRI_ST_RUN)
        else $error("init did not finish");

    // Counted init length seen on entry to RUN
    init_exact_a: assert property (
        @(posedge i_clk) disable iff (!i_rstn)
        (state_reg == CRI_ST_RUN && init_len_reg != '0) |->
            init_len_reg == CNT_W'(INIT_CLOCKS))
        else $error("init length not exact");

    init_bound_a: assert property (
        @(posedge i_clk) disable iff (!i_rstn)
        state_reg == CRI_ST_INIT |-> init_len_reg < CNT_W'(INIT_CLOCKS))
        else $error("init ran past its count");

    // Clock enable low: no output may move at that edge
    ce_freeze_a: assert property (
        @(posedge i_clk) disable iff (!i_rstn)
        !i_ce |=> $stable(o_buffered_clock_out) && $stable(o_mode) &&
            $stable(o_init_busy))
        else $error("outputs moved while clock enable low");

    mode_write_a: assert property (
        @(posedge i_clk) disable iff (!i_rstn)
        mode_write_s |=> mode_reg == $past(i_mode))
        else $error("mode write not taken");

    write_refused_a: assert property (
        @(posedge i_clk) disable iff (!i_rstn)
        (i_ce && i_mode_wr && (state_reg != CRI_ST_RUN || !rst_sync_reg))
        |=> mode_reg == mode_default())
        else $error("mode write taken during init");

    mode_shown_a: assert property (
        @(posedge i_clk) disable iff (!i_rstn)
        i_ce |=> o_mode == $past(mode_reg))
        else $error("mode output lags its register");

    busy_init_a: assert property (
        @(posedge i_clk) disable iff (!i_rstn)
        (i_ce && state_reg != CRI_ST_RUN) |=> o_init_busy)
        else $error("busy flag low during init");

    hold_exit_a: assert property (
        @(posedge i_clk) disable iff (!i_rstn)
        init_start_s |=> state_reg == CRI_ST_INIT && cnt_reg == '0)
        else $error("init did not start from zero");
endmodule
`default_nettype wire

/* File: core/cri_pkg.sv */
// Functional notes
// - Drive buffered system clock copy on clock output, full or half rate.
// - Half-rate select bit chooses full or half rate clock output.
// - Output-enable bit gates the clock output; defaults enabled after init.
// - Power-on: 1024-clock initialization, then all mode settings at defaults.
// - External reset release starts 1024-clock initialization, then defaults.
package cri_pkg;
    localparam int CLK_PERIOD_NS = 100;
    localparam int INIT_CLOCKS = 1024;
    localparam int CNT_W = 11;
    localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(INIT_CLOCKS - 1);
    localparam logic DIV_RESET = 1'b0;
    localparam logic EN_RESET = 1'b1;

    typedef enum logic [2:0] {
        CRI_ST_HOLD = 3'b001,
        CRI_ST_INIT = 3'b010,
        CRI_ST_RUN = 3'b100
    } cri_state_e;

    typedef struct packed {
        logic half_rate_sel;
        logic enable_bit;
    } cri_mode_s;
endpackage

/* File: tb/clock_output_and_reset_init_tb.sv */
`timescale 1ns/1ns
`default_nettype none
module clock_output_and_reset_init_tb;
    import cri_pkg::*;
    logic i_clk, i_rstn, i_ce, req, ext_n, i_mode_wr, o_clk, o_busy, prv;
    cri_mode_s i_mode, o_mode, m;
    int mismatches, total_checks, n;
    logic [31:0] seed;
    cri_clkout uut(.i_clk(i_clk), .i_rstn(i_rstn), .i_ce(i_ce),
        .i_external_reset_low(ext_n), .i_mode(i_mode),
        .i_mode_wr(i_mode_wr), .o_buffered_clock_out(o_clk),
        .o_init_busy(o_busy), .o_mode(o_mode));
    cri_rst_ctrl ctrl(.i_clk(i_clk), .i_req(req),
        .o_external_reset_low(ext_n));
    // One fixed-rate clock, running from time zero
    initial begin
        i_clk = 1'b0;
        forever #(CLK_PERIOD_NS / 2) i_clk = ~i_clk;
    end
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction
    function automatic int exp_tog(input cri_mode_s v);
        return v.enable_bit ? (v.half_rate_sel ? 4 : 8) : 0;
    endfunction
    task automatic chk(input string w, input logic [31:0] e,
        input logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            mismatches++;
            $display("[FAIL] %s expected %0d seen %0d", w, e, g);
        end
    endtask
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    // Sync stages allow a few cycles of slack on the count
    task automatic wait_init;
        n = 0;
        while (o_busy !== 1'b0 && n < 1100) begin
            @(negedge i_clk);
            n++;
        end
        if (n >= 1100) begin
            chk("init done", 0, 32'(o_busy));
            end_of_test();
        end else begin
            m = '{half_rate_sel: DIV_RESET, enable_bit: EN_RESET};
            chk("init long", 1, 32'(n >= 1024 && n <= 1028));
            chk("mode default", 32'(m), 32'(o_mode));
        end
    endtask
    initial begin
        {i_ce, i_rstn, i_mode, i_mode_wr, req} = 6'h20;
        {seed, mismatches, total_checks} = '0;
        seed[3:0] = 4'h9;
        repeat (8) @(negedge i_clk);
        i_rstn = 1'b1;
        wait_init();
        for (int k = 0; k < 12; k++) begin
            seed = xs(seed);
            m = cri_mode_s'(k < 4 ? k[1:0] : seed[1:0]);
            {i_mode, i_mode_wr} = {m, 1'b1};
            @(negedge i_clk);
            i_mode_wr = 1'b0;
            repeat (2) @(negedge i_clk);
            chk("mode", 32'(m), 32'(o_mode));
            n = 0;
            repeat (8) begin
                prv = o_clk;
                @(negedge i_clk);
                if (o_clk !== prv) n++;
            end
            chk("toggles", exp_tog(m), n);
            if (!m.enable_bit) chk("clk off", 0, 32'(o_clk));
        end
        // Full rate first, so that a frozen output can be seen
        {i_mode, i_mode_wr} = 3'h3;
        @(negedge i_clk);
        i_mode_wr = 1'b0;
        repeat (2) @(negedge i_clk);
        prv = o_clk;
        // Clock enable low: a write offered meanwhile must not land
        {i_ce, i_mode, i_mode_wr} = 4'h7;
        repeat (4) @(negedge i_clk);
        chk("frozen clk", 32'(prv), 32'(o_clk));
        chk("frozen mode", 32'h1, 32'(o_mode));
        // Restart and leave a non-default mode for the reset to clear
        {i_ce, i_mode, i_mode_wr} = 4'hd;
        @(negedge i_clk);
        {req, i_mode_wr} = 2'b10;
        @(negedge i_clk);
        req = 1'b0;
        for (int k = 0; k < 9 && ext_n !== 1'b1; k++) @(negedge i_clk);
        chk("reset pin high", 1, 32'(ext_n));
        // Synchronised reset still low here, so the write is refused
        i_mode_wr = 1'b1;
        @(negedge i_clk);
        i_mode_wr = 1'b0;
        @(negedge i_clk);
        chk("refused write", 32'h1, 32'(o_mode));
        wait_init();
        end_of_test();
    end
endmodule
`default_nettype wire

/* File: tb/cri_rst_ctrl.sv */
`timescale 1ns/1ns
`default_nettype none
module cri_rst_ctrl (
    input wire logic i_clk, // System clock
    input wire logic i_req, // Start a reset pulse
    output logic o_external_reset_low // Reset pin drive
);
    int cnt;
    // Low from power-up, then five cycles per request
    // Changes by non-blocking assignment on the rising edge, so the
    // request from the bench is never raced.
    initial begin
        cnt = 4;
        o_external_reset_low = 1'b0;
        forever begin
            @(posedge i_clk);
            cnt <= i_req ? 4 : (cnt > 0 ? cnt - 1 : 0);
            o_external_reset_low <= (cnt == 0) && !i_req;
        end
    end
endmodule
`default_nettype wire
